// *** rtl/nmt_device.sv ***
// Overview of operation
// - oscillator plus quadrature mixer gives complex baseband
// - control bits 5:4 choose the if mode
// - variable mode runs oscillator and mixer
// - zero-if bypasses mixer, oscillator stopped
// - quarter-rate mode uses dedicated cheap down-mix
// - test mode forces input to 0.999 full scale
// - real mixing loses image plus oscillator loss
// - host should add 6 dB gain afterwards
// - complex mixing scaled by 0.707
// - step word is 12-bit two's complement
// - frequency equals step word times rate over 4096
// - 12-bit phase start word per oscillator
// - host writes steps, then phases, then syncs
// - sync loads phase start, then advance by step
// - soft reset bit 4 resets accumulators
// - enabled reference pulse resets accumulators
// - two multipliers real, four plus adders complex
// - control bit 7 selects real or complex
`timescale 1ns/10ps
`include "nmt_consts.svh"
module nmt_device
#(
	parameter logic [11:0] CTRL_ADDR = `NMT_CH0_CTRL_ADDR
)
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	nmt_if.dev link,
	input wire logic adc_valid_in,
	output logic adc_ready_out,
	input wire logic signed [15:0] adc_i_in,
	input wire logic signed [15:0] adc_q_in,
	input wire logic system_reference_pulse_in,
	output logic [11:0] phase_accumulator_value_out
);
	import nmt_pkg::*;

	// ************************************************************
	// sine lookup
	// ************************************************************

	// quarter-wave table, index 0..16 of 16 steps per quadrant
	function automatic logic signed [15:0] quarter_sine(input logic [4:0] idx);
		logic signed [15:0] v;
		v = 16'sh0000;
		case (idx)
			5'h00: v = 16'sh0000;
			5'h01: v = 16'sh0c79;
			5'h02: v = 16'sh18d4;
			5'h03: v = 16'sh24f1;
			5'h04: v = 16'sh30b3;
			5'h05: v = 16'sh3bfe;
			5'h06: v = 16'sh46b4;
			5'h07: v = 16'sh50bc;
			5'h08: v = 16'sh59fd;
			5'h09: v = 16'sh6260;
			5'h0a: v = 16'sh69d0;
			5'h0b: v = 16'sh703c;
			5'h0c: v = 16'sh7593;
			5'h0d: v = 16'sh79c8;
			5'h0e: v = 16'sh7cd1;
			5'h0f: v = 16'sh7ea5;
			default: v = `NMT_SINE_PEAK;
		endcase
		return v;
	endfunction

	// sine of a 12-bit phase from its top six bits
	function automatic logic signed [15:0] nco_sine(input logic [11:0] ph);
		logic [4:0] idx;
		logic signed [15:0] mag;
		idx = {1'b0, ph[9:6]};
		if (ph[10])
		begin
			idx = 5'h10 - idx;
		end
		mag = quarter_sine(idx);
		return ph[11] ? -mag : mag;
	endfunction

	// clamp a wide signed value into 16 bits
	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		logic signed [15:0] r;
		r = v[15:0];
		if (v > 48'sh0000_0000_7fff)
		begin
			r = 16'sh7fff;
		end
		else if (v < -48'sh0000_0000_8000)
		begin
			r = 16'sh8000;
		end
		return r;
	endfunction

	// ************************************************************
	// state
	// ************************************************************

	nmt_dev_state_type s_r;
	nmt_dev_state_type s_nxt;

	nmt_mode_type mode;
	logic is_cplx;
	logic take;
	logic sync_evt;
	logic signed [15:0] x_i;
	logic signed [15:0] x_q;
	logic signed [15:0] lo_cos;
	logic signed [15:0] lo_sin;
	logic signed [47:0] mix_i;
	logic signed [47:0] mix_q;
	logic signed [47:0] rot_i;
	logic signed [47:0] rot_q;
	logic signed [15:0] res_i;
	logic signed [15:0] res_q;

	// ************************************************************
	// datapath
	// ************************************************************

	// configuration decode
	always_comb
	begin
		mode = nmt_mode_type'(s_r.ctrl[`NMT_CTRL_MODE_HI:`NMT_CTRL_MODE_LO]);
		is_cplx = s_r.ctrl[`NMT_CTRL_CPLX_BIT];
		adc_ready_out = !s_r.out_valid || link.bb_ready;
		take = adc_valid_in && adc_ready_out;
		sync_evt = s_r.sync[`NMT_SYNC_SOFT_BIT] ||
			(system_reference_pulse_in && s_r.sref_a[`NMT_SREF_EN_BIT] &&
			(|s_r.sync[`NMT_SYNC_EN_HI:`NMT_SYNC_EN_LO]));
	end

	// mixer arithmetic for the sample being taken
	always_comb
	begin
		x_i = (mode == NMT_MODE_TEST) ? `NMT_TEST_LEVEL : adc_i_in;
		x_q = is_cplx ? ((mode == NMT_MODE_TEST) ? `NMT_TEST_LEVEL : adc_q_in) : 16'sh0000;
		lo_sin = nco_sine(s_r.acc);
		lo_cos = nco_sine(s_r.acc + `NMT_QUARTER_TURN);
		// real path uses the two x_i products only
		if (is_cplx)
		begin
			mix_i = (48'(x_i * lo_cos) + 48'(x_q * lo_sin)) >>> 15;
			mix_q = (48'(x_q * lo_cos) - 48'(x_i * lo_sin)) >>> 15;
		end
		else
		begin
			mix_i = 48'(x_i * lo_cos) >>> 15;
			mix_q = -(48'(x_i * lo_sin) >>> 15);
		end
		// rotate by 1, -j, -1, +j
		case (s_r.qphase)
			2'd0:
			begin
				rot_i = 48'(x_i);
				rot_q = 48'(x_q);
			end
			2'd1:
			begin
				rot_i = 48'(x_q);
				rot_q = -48'(x_i);
			end
			2'd2:
			begin
				rot_i = -48'(x_i);
				rot_q = -48'(x_q);
			end
			default:
			begin
				rot_i = -48'(x_q);
				rot_q = 48'(x_i);
			end
		endcase
		// quarter-rate result replaces the multiplier path
		if (mode == NMT_MODE_QUARTER)
		begin
			mix_i = rot_i;
			mix_q = rot_q;
		end
		if (is_cplx)
		begin
			mix_i = (mix_i * 48'(`NMT_CPLX_SCALE)) >>> 15;
			mix_q = (mix_q * 48'(`NMT_CPLX_SCALE)) >>> 15;
		end
		// real path keeps full-scale products, image left to filters
		res_i = sat16(mix_i);
		res_q = sat16(mix_q);
		if (mode == NMT_MODE_ZERO_IF)
		begin
			res_i = adc_i_in;
			res_q = is_cplx ? adc_q_in : 16'sh0000;
		end
	end

	// ************************************************************
	// next state
	// ************************************************************

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		// register writes
		if (link.reg_wr)
		begin
			case (link.reg_addr)
				`NMT_SREF_A_ADDR: s_nxt.sref_a = link.reg_wdata;
				`NMT_SREF_B_ADDR: s_nxt.sref_b = link.reg_wdata;
				`NMT_SYNC_ADDR: s_nxt.sync = link.reg_wdata;
				CTRL_ADDR: s_nxt.ctrl = link.reg_wdata;
				CTRL_ADDR + `NMT_FTW_LO_OFS: s_nxt.frequency_step_word[7:0] = link.reg_wdata;
				CTRL_ADDR + `NMT_FTW_HI_OFS: s_nxt.frequency_step_word[11:8] = link.reg_wdata[3:0];
				CTRL_ADDR + `NMT_POW_LO_OFS: s_nxt.phase_start_word[7:0] = link.reg_wdata;
				CTRL_ADDR + `NMT_POW_HI_OFS: s_nxt.phase_start_word[11:8] = link.reg_wdata[3:0];
				default: s_nxt.sref_b = s_nxt.sref_b;
			endcase
		end
		// register reads, answered next cycle, unmapped as zero
		if (link.reg_rd)
		begin
			s_nxt.rvalid = 1'b1;
			case (link.reg_addr)
				`NMT_SREF_A_ADDR: s_nxt.rdata = s_r.sref_a;
				`NMT_SREF_B_ADDR: s_nxt.rdata = s_r.sref_b;
				`NMT_SYNC_ADDR: s_nxt.rdata = s_r.sync;
				CTRL_ADDR: s_nxt.rdata = s_r.ctrl;
				CTRL_ADDR + `NMT_FTW_LO_OFS: s_nxt.rdata = s_r.frequency_step_word[7:0];
				CTRL_ADDR + `NMT_FTW_HI_OFS: s_nxt.rdata = {4'h0, s_r.frequency_step_word[11:8]};
				CTRL_ADDR + `NMT_POW_LO_OFS: s_nxt.rdata = s_r.phase_start_word[7:0];
				CTRL_ADDR + `NMT_POW_HI_OFS: s_nxt.rdata = {4'h0, s_r.phase_start_word[11:8]};
				CTRL_ADDR + `NMT_PAV_LO_OFS: s_nxt.rdata = s_r.acc[7:0];
				CTRL_ADDR + `NMT_PAV_HI_OFS: s_nxt.rdata = {4'h0, s_r.acc[11:8]};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		// output drained
		if (s_r.out_valid && link.bb_ready)
		begin
			s_nxt.out_valid = 1'b0;
		end
		// sample taken
		if (take)
		begin
			s_nxt.out_valid = 1'b1;
			s_nxt.out_i = res_i;
			s_nxt.out_q = res_q;
			s_nxt.qphase = s_r.qphase + 2'd1;
			// advance once per sample, wrap modulo 4096
			// step word sets frequency as ftw/4096 of rate
			if (mode == NMT_MODE_VARIABLE || mode == NMT_MODE_TEST)
			begin
				s_nxt.acc = s_r.acc + s_r.frequency_step_word;
			end
		end
		// sync loads the phase start word
		if (sync_evt)
		begin
			s_nxt.acc = s_r.phase_start_word;
			s_nxt.qphase = 2'd0;
		end
	end

	// ************************************************************
	// registers and outputs
	// ************************************************************

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s_r <= '{sref_a: `NMT_SREF_RST, sref_b: `NMT_SREF_RST, sync: `NMT_SYNC_RST,
				ctrl: `NMT_CTRL_RST, frequency_step_word: `NMT_WORD_RST, phase_start_word: `NMT_WORD_RST,
				acc: `NMT_WORD_RST, qphase: 2'd0, out_valid: 1'b0,
				out_i: 16'sh0000, out_q: 16'sh0000, rdata: 8'h00, rvalid: 1'b0};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// stream and register answers
	assign link.bb_valid = s_r.out_valid;
	assign link.bb_i = s_r.out_i;
	assign link.bb_q = s_r.out_q;
	assign link.reg_rdata = s_r.rdata;
	assign link.reg_rvalid = s_r.rvalid;
	assign phase_accumulator_value_out = s_r.acc;
endmodule

// *** rtl/nmt_consts.svh ***
`ifndef NMT_CONSTS_SVH
`define NMT_CONSTS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define NMT_SREF_A_ADDR 12'h120
`define NMT_SREF_B_ADDR 12'h121
`define NMT_SYNC_ADDR 12'h300
`define NMT_CH0_CTRL_ADDR 12'h310
`define NMT_CH1_CTRL_ADDR 12'h330
`define NMT_CH2_CTRL_ADDR 12'h350
`define NMT_CH3_CTRL_ADDR 12'h370
// offsets from a channel control register
`define NMT_FTW_LO_OFS 12'h004
`define NMT_FTW_HI_OFS 12'h005
`define NMT_POW_LO_OFS 12'h006
`define NMT_POW_HI_OFS 12'h007
`define NMT_PAV_LO_OFS 12'h008
`define NMT_PAV_HI_OFS 12'h009

// ************************************************************
// field positions
// ************************************************************
`define NMT_CTRL_CPLX_BIT 7
`define NMT_CTRL_MODE_HI 5
`define NMT_CTRL_MODE_LO 4
`define NMT_SYNC_SOFT_BIT 4
`define NMT_SYNC_EN_HI 1
`define NMT_SYNC_EN_LO 0
`define NMT_SREF_EN_BIT 0

// ************************************************************
// reset values
// ************************************************************
`define NMT_CTRL_RST 8'h00
`define NMT_SYNC_RST 8'h00
`define NMT_SREF_RST 8'h00
`define NMT_WORD_RST 12'h000

// ************************************************************
// datapath figures
// ************************************************************
// 0.999 of positive full scale
`define NMT_TEST_LEVEL 16'sh7fde
// sine peak after the 0.05 dB oscillator loss
`define NMT_SINE_PEAK 16'sh7f43
// 0.707 in q15
`define NMT_CPLX_SCALE 16'sh5a82
// a quarter turn of the 4096-step phase circle
`define NMT_QUARTER_TURN 12'h400

`endif

// *** rtl/nmt_pkg.sv ***
package nmt_pkg;

	// if mode field encoding
	typedef enum logic [1:0]
	{
		NMT_MODE_VARIABLE,
		NMT_MODE_ZERO_IF,
		NMT_MODE_QUARTER,
		NMT_MODE_TEST
	} nmt_mode_type;

	// device end state
	typedef struct packed
	{
		logic [7:0] sref_a;
		logic [7:0] sref_b;
		logic [7:0] sync;
		logic [7:0] ctrl;
		logic [11:0] frequency_step_word;
		logic [11:0] phase_start_word;
		logic [11:0] acc;
		logic [1:0] qphase;
		logic out_valid;
		logic signed [15:0] out_i;
		logic signed [15:0] out_q;
		logic [7:0] rdata;
		logic rvalid;
	} nmt_dev_state_type;

	// host end sequencer states
	typedef enum
	{
		NMT_H_IDLE,
		NMT_H_FTW_LO,
		NMT_H_FTW_HI,
		NMT_H_POW_LO,
		NMT_H_POW_HI,
		NMT_H_SYNC_SET,
		NMT_H_SYNC_CLR,
		NMT_H_RD_WAIT
	} nmt_host_fsm_type;

	// host end state
	typedef struct packed
	{
		nmt_host_fsm_type fsm;
		logic [11:0] frequency_step_word;
		logic [11:0] phase_start_word;
		logic [7:0] sync_shadow;
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic rdata_valid;
	} nmt_host_state_type;

endpackage

// *** rtl/nmt_if.sv ***
`timescale 1ns/10ps
interface nmt_if;
	// register port
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	// baseband stream
	logic bb_valid;
	logic bb_ready;
	logic signed [15:0] bb_i;
	logic signed [15:0] bb_q;

	modport dev
	(
		input reg_addr, reg_wdata, reg_wr, reg_rd, bb_ready,
		output reg_rdata, reg_rvalid, bb_valid, bb_i, bb_q
	);

	modport hst
	(
		output reg_addr, reg_wdata, reg_wr, reg_rd, bb_ready,
		input reg_rdata, reg_rvalid, bb_valid, bb_i, bb_q
	);
endinterface

// *** rtl/nmt_host.sv ***
`timescale 1ns/10ps
`include "nmt_consts.svh"
// ************************************************************
// stream fifo
// ************************************************************
module nmt_fifo
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
)
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	import nmt_pkg::*;
	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wptr;
		logic [AW:0] rptr;
	} nmt_fifo_state_type;

	nmt_fifo_state_type s_r;
	nmt_fifo_state_type s_nxt;
	logic [AW:0] fill;

	// flags and pointer update
	always_comb
	begin
		fill = s_r.wptr - s_r.rptr;
		in_ready_out = (fill != (AW+1)'(DEPTH));
		out_valid_out = (fill != '0);
		out_data_out = s_r.mem[s_r.rptr[AW-1:0]];
		s_nxt = s_r;
		if (in_valid_in && in_ready_out)
		begin
			s_nxt.mem[s_r.wptr[AW-1:0]] = in_data_in;
			s_nxt.wptr = s_r.wptr + 1'b1;
		end
		if (out_valid_out && out_ready_in)
		begin
			s_nxt.rptr = s_r.rptr + 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end
endmodule

// ************************************************************
// host and downstream end
// ************************************************************
module nmt_host
#(
	parameter logic [11:0] CTRL_ADDR = `NMT_CH0_CTRL_ADDR,
	parameter int FIFO_DEPTH = 32
)
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	nmt_if.hst link,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic cmd_write_in,
	input wire logic [11:0] cmd_addr_in,
	input wire logic [7:0] cmd_wdata_in,
	output logic [7:0] rdata_out,
	output logic rdata_valid_out,
	input wire logic tune_valid_in,
	output logic tune_ready_out,
	input wire logic [11:0] tune_frequency_step_word_in,
	input wire logic [11:0] tune_phase_start_word_in,
	input wire logic gain_6db_in,
	output logic bb_valid_out,
	input wire logic bb_ready_in,
	output logic signed [15:0] bb_i_out,
	output logic signed [15:0] bb_q_out
);
	import nmt_pkg::*;

	// double with clamp
	function automatic logic signed [15:0] gain2(input logic signed [15:0] v);
		logic signed [15:0] r;
		r = {v[14:0], 1'b0};
		if (v[15] != v[14])
		begin
			r = v[15] ? 16'sh8000 : 16'sh7fff;
		end
		return r;
	endfunction

	nmt_host_state_type s_r;
	nmt_host_state_type s_nxt;
	logic signed [15:0] g_i;
	logic signed [15:0] g_q;

	// sequencer
	always_comb
	begin
		tune_ready_out = (s_r.fsm == NMT_H_IDLE);
		cmd_ready_out = (s_r.fsm == NMT_H_IDLE) && !tune_valid_in;
		s_nxt = s_r;
		s_nxt.wr = 1'b0;
		s_nxt.rd = 1'b0;
		s_nxt.rdata_valid = 1'b0;
		case (s_r.fsm)
			NMT_H_IDLE:
			begin
				if (tune_valid_in)
				begin
					s_nxt.frequency_step_word = tune_frequency_step_word_in;
					s_nxt.phase_start_word = tune_phase_start_word_in;
					s_nxt.fsm = NMT_H_FTW_LO;
				end
				else if (cmd_valid_in)
				begin
					s_nxt.addr = cmd_addr_in;
					s_nxt.wdata = cmd_wdata_in;
					s_nxt.wr = cmd_write_in;
					s_nxt.rd = !cmd_write_in;
					if (cmd_write_in && cmd_addr_in == `NMT_SYNC_ADDR)
					begin
						s_nxt.sync_shadow = cmd_wdata_in;
					end
					if (!cmd_write_in)
					begin
						s_nxt.fsm = NMT_H_RD_WAIT;
					end
				end
			end
			NMT_H_FTW_LO:
			begin
				s_nxt.wr = 1'b1;
				s_nxt.addr = CTRL_ADDR + `NMT_FTW_LO_OFS;
				s_nxt.wdata = s_r.frequency_step_word[7:0];
				s_nxt.fsm = NMT_H_FTW_HI;
			end
			NMT_H_FTW_HI:
			begin
				s_nxt.wr = 1'b1;
				s_nxt.addr = CTRL_ADDR + `NMT_FTW_HI_OFS;
				s_nxt.wdata = {4'h0, s_r.frequency_step_word[11:8]};
				s_nxt.fsm = NMT_H_POW_LO;
			end
			NMT_H_POW_LO:
			begin
				s_nxt.wr = 1'b1;
				s_nxt.addr = CTRL_ADDR + `NMT_POW_LO_OFS;
				s_nxt.wdata = s_r.phase_start_word[7:0];
				s_nxt.fsm = NMT_H_POW_HI;
			end
			NMT_H_POW_HI:
			begin
				s_nxt.wr = 1'b1;
				s_nxt.addr = CTRL_ADDR + `NMT_POW_HI_OFS;
				s_nxt.wdata = {4'h0, s_r.phase_start_word[11:8]};
				s_nxt.fsm = NMT_H_SYNC_SET;
			end
			NMT_H_SYNC_SET:
			begin
				s_nxt.wr = 1'b1;
				s_nxt.addr = `NMT_SYNC_ADDR;
				s_nxt.wdata = s_r.sync_shadow | 8'h10;
				s_nxt.fsm = NMT_H_SYNC_CLR;
			end
			NMT_H_SYNC_CLR:
			begin
				s_nxt.wr = 1'b1;
				s_nxt.addr = `NMT_SYNC_ADDR;
				s_nxt.wdata = s_r.sync_shadow & 8'hef;
				s_nxt.sync_shadow = s_r.sync_shadow & 8'hef;
				s_nxt.fsm = NMT_H_IDLE;
			end
			NMT_H_RD_WAIT:
			begin
				if (link.reg_rvalid)
				begin
					s_nxt.rdata = link.reg_rdata;
					s_nxt.rdata_valid = 1'b1;
					s_nxt.fsm = NMT_H_IDLE;
				end
			end
			default: s_nxt.fsm = NMT_H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s_r <= '{fsm: NMT_H_IDLE, frequency_step_word: `NMT_WORD_RST, phase_start_word: `NMT_WORD_RST,
				sync_shadow: `NMT_SYNC_RST, wr: 1'b0, rd: 1'b0, addr: 12'h000,
				wdata: 8'h00, rdata: 8'h00, rdata_valid: 1'b0};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// optional 6 dB gain doubles both I and Q whenever gain_6db_in is set, real or complex, with clamp
	always_comb
	begin
		g_i = gain_6db_in ? gain2(link.bb_i) : link.bb_i;
		g_q = gain_6db_in ? gain2(link.bb_q) : link.bb_q;
	end

	// baseband buffer toward the user side
	nmt_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.in_valid_in(link.bb_valid),
		.in_ready_out(link.bb_ready),
		.in_data_in({g_i, g_q}),
		.out_valid_out(bb_valid_out),
		.out_ready_in(bb_ready_in),
		.out_data_out({bb_i_out, bb_q_out})
	);

	// register port drive
	assign link.reg_wr = s_r.wr;
	assign link.reg_rd = s_r.rd;
	assign link.reg_addr = s_r.addr;
	assign link.reg_wdata = s_r.wdata;
	assign rdata_out = s_r.rdata;
	assign rdata_valid_out = s_r.rdata_valid;
endmodule

// *** dv/nmt_link_chk.sv ***
`timescale 1ns/10ps
`include "nmt_consts.svh"
// ************************************************************
// link checker
// ************************************************************
module nmt_link_chk
#(
	parameter logic [11:0] CTRL_ADDR = `NMT_CH0_CTRL_ADDR
)
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic bb_valid,
	input wire logic bb_ready,
	input wire logic signed [15:0] bb_i,
	input wire logic signed [15:0] bb_q
);
	logic [7:0] ctrl_r;
	logic [3:0] fhi_r;
	logic mapped;

	// shadows of the written control byte and step hi nibble
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ctrl_r <= 8'h00;
			fhi_r <= 4'h0;
		end
		else if (reg_wr)
		begin
			if (reg_addr == CTRL_ADDR)
				ctrl_r <= reg_wdata;
			if (reg_addr == CTRL_ADDR + `NMT_FTW_HI_OFS)
				fhi_r <= reg_wdata[3:0];
		end
	end

	// decode of the addresses that answer
	assign mapped = (reg_addr inside {`NMT_SREF_A_ADDR, `NMT_SREF_B_ADDR, `NMT_SYNC_ADDR, CTRL_ADDR})
		|| (reg_addr >= CTRL_ADDR + `NMT_FTW_LO_OFS && reg_addr <= CTRL_ADDR + `NMT_PAV_HI_OFS);

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!resetn_in);

	read_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered in the next cycle");
	answer_cause_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read answer without a read");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	ctrl_back_a: assert property (reg_rd && reg_addr == CTRL_ADDR |=> reg_rdata == $past(ctrl_r))
		else $error("control readback wrong");
	step_nibble_a: assert property (reg_rd && reg_addr == CTRL_ADDR + `NMT_FTW_HI_OFS
		|=> reg_rdata == {4'h0, $past(fhi_r)})
		else $error("step hi readback wrong");
	bb_hold_a: assert property (bb_valid && !bb_ready
		|=> bb_valid && $stable(bb_i) && $stable(bb_q))
		else $error("baseband beat dropped or changed while stalled");
	zero_if_q_a: assert property (bb_valid && ctrl_r[5:4] == 2'b01 && !ctrl_r[7]
		|-> bb_q == 16'sh0000)
		else $error("zero if real output has nonzero q");
endmodule

// *** dv/nmt_tb.sv ***
`timescale 1ns/10ps
`include "nmt_consts.svh"
// ************************************************************
// bench for the translation stage
// ************************************************************
module nmt_tb;
	import nmt_pkg::*;
	localparam logic [11:0] CTRL = `NMT_CH0_CTRL_ADDR;
	localparam int PK = (int'(`NMT_TEST_LEVEL) * int'(`NMT_SINE_PEAK)) >>> 15;
	localparam int PC = (PK * int'(`NMT_CPLX_SCALE)) >>> 15;
	localparam int VH = (int'(16'sh4000) * int'(`NMT_SINE_PEAK)) >>> 15;
	logic clk, resetn, adc_valid, adc_ready, pulse, cmd_valid, cmd_ready, cmd_write;
	logic rdata_valid, tune_valid, tune_ready, gain, bb_valid, bb_ready;
	logic signed [15:0] adc_i, adc_q, bb_i, bb_q;
	logic [11:0] acc, cmd_addr, tune_ftw, tune_pow;
	logic [7:0] cmd_wdata, rdata;
	int n_errors, checked;
	logic [15:0] qi[$];
	logic [15:0] qq[$];

	nmt_if link();
	nmt_device #(.CTRL_ADDR(CTRL)) u_nmt_device (.core_clk_in(clk), .resetn_in(resetn),
		.link(link), .adc_valid_in(adc_valid), .adc_ready_out(adc_ready), .adc_i_in(adc_i),
		.adc_q_in(adc_q), .system_reference_pulse_in(pulse), .phase_accumulator_value_out(acc));
	nmt_host #(.CTRL_ADDR(CTRL), .FIFO_DEPTH(32)) u_nmt_host (.core_clk_in(clk),
		.resetn_in(resetn), .link(link), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
		.cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
		.rdata_out(rdata), .rdata_valid_out(rdata_valid), .tune_valid_in(tune_valid),
		.tune_ready_out(tune_ready), .tune_frequency_step_word_in(tune_ftw),
		.tune_phase_start_word_in(tune_pow), .gain_6db_in(gain), .bb_valid_out(bb_valid),
		.bb_ready_in(bb_ready), .bb_i_out(bb_i), .bb_q_out(bb_q));
	nmt_link_chk #(.CTRL_ADDR(CTRL)) u_nmt_link_chk (.core_clk_in(clk), .resetn_in(resetn),
		.reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
		.reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid),
		.bb_valid(link.bb_valid), .bb_ready(link.bb_ready), .bb_i(link.bb_i), .bb_q(link.bb_q));

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic logic sel(input int w);
		case (w)
			0: return cmd_ready;
			1: return adc_ready;
			2: return rdata_valid;
			3: return tune_ready;
			default: return qi.size() != 0;
		endcase
	endfunction

	// bounded wait on one handshake, judged between edges
	task automatic wait_hi(input int w);
		int n;
		n = 0;
		@(negedge clk);
		while (sel(w) !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 80)
			begin
				n_errors++;
				end_of_test();
			end
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= 1'b1;
		cmd_addr <= a;
		cmd_wdata <= d;
		wait_hi(0);
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= 1'b0;
		cmd_addr <= a;
		wait_hi(0);
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_hi(2);
		chk("rdata", {8'h00, rdata}, {8'h00, e});
	endtask

	task automatic tune(input logic [11:0] f, input logic [11:0] p);
		@(posedge clk);
		tune_valid <= 1'b1;
		tune_ftw <= f;
		tune_pow <= p;
		wait_hi(3);
		@(posedge clk);
		tune_valid <= 1'b0;
		wait_hi(3);
	endtask

	task automatic push(input logic [15:0] i, input logic [15:0] q);
		@(posedge clk);
		adc_valid <= 1'b1;
		adc_i <= i;
		adc_q <= q;
		wait_hi(1);
		@(posedge clk);
		adc_valid <= 1'b0;
	endtask

	task automatic get(input logic [15:0] ei, input logic [15:0] eq);
		wait_hi(4);
		chk("bb_i", qi.pop_front(), ei);
		chk("bb_q", qq.pop_front(), eq);
	endtask

	task automatic strobe;
		@(posedge clk);
		pulse <= 1'b1;
		@(posedge clk);
		pulse <= 1'b0;
		repeat (4) @(negedge clk);
	endtask

	task automatic s_regs;
		rdc(CTRL, 8'h00);
		rdc(`NMT_SYNC_ADDR, 8'h00);
		wr(CTRL, 8'hb0);
		rdc(CTRL, 8'hb0);
		wr(CTRL + `NMT_FTW_HI_OFS, 8'hff);
		rdc(CTRL + `NMT_FTW_HI_OFS, 8'h0f);
		wr(CTRL + `NMT_POW_HI_OFS, 8'hf3);
		rdc(CTRL + `NMT_POW_HI_OFS, 8'h03);
		wr(`NMT_SREF_B_ADDR, 8'ha5);
		rdc(`NMT_SREF_B_ADDR, 8'ha5);
		wr(12'h200, 8'h77);
		rdc(12'h200, 8'h00);
	endtask

	task automatic s_modes;
		logic [11:0] f[2] = '{12'h100, 12'hfff};
		wr(CTRL, 8'h10);
		push(16'h1234, 16'h4321);
		push(16'h8001, 16'h4321);
		get(16'h1234, 16'h0000);
		get(16'h8001, 16'h0000);
		wr(CTRL, 8'h90);
		push(16'h1234, 16'h4321);
		get(16'h1234, 16'h4321);
		chk("acc", {4'h0, acc}, 16'h0000);
		tune(12'h400, 12'h000);
		chk("acc", {4'h0, acc}, 16'h0000);
		wr(CTRL, 8'h30);
		push(16'h0000, 16'h0000);
		get(16'(PK), 16'h0000);
		chk("acc", {4'h0, acc}, 16'h0400);
		tune(12'h400, 12'h000);
		wr(CTRL, 8'hb0);
		push(16'h0000, 16'h0000);
		get(16'(PC), 16'(PC));
		wr(CTRL, 8'h00);
		foreach (f[k])
		begin
			tune(f[k], 12'h000);
			push(16'h4000, 16'h0000);
			get(16'(VH), 16'h0000);
			chk("acc", {4'h0, acc}, {4'h0, f[k]});
		end
	endtask

	task automatic s_quarter;
		tune(12'h000, 12'h000);
		wr(CTRL, 8'h20);
		gain <= 1'b1;
		repeat (4) push(16'h1000, 16'h0000);
		get(16'h2000, 16'h0000);
		get(16'h0000, 16'he000);
		get(16'he000, 16'h0000);
		get(16'h0000, 16'h2000);
		@(posedge clk);
		gain <= 1'b0;
	endtask

	task automatic s_sync;
		wr(CTRL, 8'h00);
		tune(12'h010, 12'h321);
		// phase 0x321: cos step 4 of the table, sin step 12, half-scale input
		push(16'h4000, 16'h0000);
		get(16'h1859, 16'hc537);
		wr(`NMT_SREF_A_ADDR, 8'h00);
		wr(`NMT_SYNC_ADDR, 8'h01);
		strobe();
		chk("acc", {4'h0, acc}, 16'h0331);
		wr(`NMT_SREF_A_ADDR, 8'h01);
		strobe();
		chk("acc", {4'h0, acc}, 16'h0321);
		push(16'h0000, 16'h0000);
		get(16'h0000, 16'h0000);
		wr(`NMT_SYNC_ADDR, 8'h11);
		repeat (4) @(negedge clk);
		chk("acc", {4'h0, acc}, 16'h0321);
		wr(`NMT_SYNC_ADDR, 8'h01);
	endtask

	task automatic s_fifo;
		int taken;
		taken = 0;
		wr(CTRL, 8'h10);
		@(posedge clk);
		bb_ready <= 1'b0;
		adc_valid <= 1'b1;
		adc_i <= 16'h0000;
		repeat (45)
		begin
			@(negedge clk);
			if (adc_ready === 1'b1)
			begin
				@(posedge clk);
				taken++;
				adc_i <= 16'(taken);
			end
		end
		chk("taken", 16'(taken), 16'(33));
		@(posedge clk);
		bb_ready <= 1'b1;
		wait_hi(1);
		@(posedge clk);
		adc_valid <= 1'b0;
		for (int k = 0; k < 34; k++)
			get(16'(k), 16'h0000);
		repeat (4) @(negedge clk);
		chk("bb_valid", {15'h0, bb_valid}, 16'h0000);
	endtask

	// record each beat that leaves the fifo
	always @(negedge clk)
	begin
		if (bb_valid === 1'b1 && bb_ready === 1'b1)
		begin
			qi.push_back(bb_i);
			qq.push_back(bb_q);
		end
	end

	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// reset, then the scenarios in turn
	initial
	begin
		{n_errors, checked} = '0;
		{resetn, adc_valid, pulse, cmd_valid, cmd_write, tune_valid, gain} = '0;
		{adc_i, adc_q, cmd_addr, cmd_wdata, tune_ftw, tune_pow} = '0;
		bb_ready = 1'b1;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		s_regs();
		s_modes();
		s_quarter();
		s_sync();
		s_fifo();
		end_of_test();
	end
endmodule
